/* File: pack_status_pkg.sv */
`default_nettype none
package pack_status_pkg;

  // Register map
  localparam logic [7:0] CFG_STATUS_ADDR = 8'h00;
  localparam logic [7:0] FAULT_STATUS_ADDR = 8'h01;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field positions
  localparam int SINGLE_FE_BIT = 5;
  localparam int WAKE_BIT = 4;
  localparam int EXT_OT_BIT = 5;
  localparam int INT_OT_BIT = 4;
  localparam int LOAD_FAIL_BIT = 3;
  localparam int DIS_SHORT_BIT = 2;
  localparam int DIS_OC_BIT = 1;
  localparam int CHG_OC_BIT = 0;

  // Fixed and reset values
  localparam logic SINGLE_FE_VALUE = 1'b1;
  localparam logic [5:0] FAULT_RESET = 6'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [2:0] BITCNT_RESET = 3'h0;
  localparam logic LINE_IDLE = 1'b1;

  // Bus address, arbitrary value
  localparam logic [6:0] DEF_BUS_ADDR = 7'h2A;

  // Raw pins from the analog side, not on clk
  typedef struct packed {
    logic extOverTemp;
    logic intOverTemp;
    logic dischargeShort;
    logic dischargeOvercurrent;
    logic chargeOvercurrent;
    logic loadHeavy;
    logic wakeAbove;
  } pin_in_s;

  localparam pin_in_s PIN_RESET = '0;

  // Order matches fault status bits 5..0
  typedef struct packed {
    logic extOverTemp;
    logic intOverTemp;
    logic loadFail;
    logic dischargeShort;
    logic dischargeOvercurrent;
    logic chargeOvercurrent;
  } fault_vec_s;

  typedef enum {BUS_IDLE, BUS_RX, BUS_RXACK, BUS_TX, BUS_TXACK} bus_state_e;
  typedef enum {BYTE_ADDR, BYTE_PTR, BYTE_DATA} byte_kind_e;

endpackage
`default_nettype wire

/* File: pack_protection_status_regs.sv */
// Function
// - Config status bit 5 always reads 1 and no write changes it.
// - Config status bit 4 follows the wake pin comparison, never a write.
// - With wake polarity high the wake bit is 1 when the pin is above threshold.
// - With wake polarity low the wake bit is 1 when the pin is below threshold.
// - Fault bit 5 sets on external over-temperature; a read clears it once gone.
// - Fault bit 4 sets on internal over-temperature; a read clears it once gone.
// - Fault bit 3 sets on discharge fault under heavy load when monitoring is on.
// - Fault bit 2 sets on discharge short; a read clears it once removed.
// - Fault bit 1 sets on discharge overcurrent; a read clears it once removed.
// - Fault bit 0 sets on charge overcurrent; a read clears it once removed.
// - Reading the fault register clears flags whose fault is gone; a live fault keeps its flag; other bits are live.
`timescale 1ns/10ps
`default_nettype none
module pack_protection_status_regs
  import pack_status_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = DEF_BUS_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire pin_in_s pins,
  input wire logic wakePolarity,
  input wire logic loadMonitorEnable
);

  // Reserved bus addresses cannot be served
  if (BUS_ADDR[6:3] == 4'b0000 || BUS_ADDR[6:3] == 4'b1111) begin : g_chk
    $error("BUS_ADDR lies in a reserved bus address range");
  end

  pin_in_s pinMeta;
  pin_in_s pinSync;
  logic sclMeta;
  logic sclSync;
  logic sclPrev;
  logic sdaMeta;
  logic sdaSync;
  logic sdaPrev;

  bus_state_e stateReg;
  bus_state_e stateNext;
  byte_kind_e kindReg;
  byte_kind_e kindNext;
  logic [2:0] bitCntReg;
  logic [2:0] bitCntNext;
  logic [7:0] shiftReg;
  logic [7:0] shiftNext;
  logic rxFullReg;
  logic rxFullNext;
  logic readModeReg;
  logic readModeNext;
  logic [7:0] ptrReg;
  logic [7:0] ptrNext;
  logic sdaOeReg;
  logic sdaOeNext;
  fault_vec_s faultReg;
  fault_vec_s faultNext;

  wire logic sclRise;
  wire logic sclFall;
  wire logic startCond;
  wire logic stopCond;
  wire logic wakeStatus;
  wire logic [7:0] cfgStatus;
  wire logic [7:0] faultStatus;
  wire logic [7:0] readData;
  wire logic addrMatch;
  wire logic loadTx;
  wire logic readClr;
  wire fault_vec_s faultCond;

  // Two stages on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta <= PIN_RESET;
      pinSync <= PIN_RESET;
      sclMeta <= LINE_IDLE;
      sclSync <= LINE_IDLE;
      sclPrev <= LINE_IDLE;
      sdaMeta <= LINE_IDLE;
      sdaSync <= LINE_IDLE;
      sdaPrev <= LINE_IDLE;
    end else if (clkEn) begin
      pinMeta <= pins;
      pinSync <= pinMeta;
      sclMeta <= scl;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  assign sclRise = sclSync & ~sclPrev;
  assign sclFall = ~sclSync & sclPrev;
  assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;

  // Live config status; no storage, so writes cannot reach it
  assign wakeStatus = ~(wakePolarity ^ pinSync.wakeAbove);
  assign cfgStatus = {2'b00, SINGLE_FE_VALUE, wakeStatus, 4'h0};

  // Live fault conditions
  assign faultCond.extOverTemp = pinSync.extOverTemp;
  assign faultCond.intOverTemp = pinSync.intOverTemp;
  assign faultCond.loadFail = loadMonitorEnable & pinSync.loadHeavy &
    (pinSync.dischargeShort | pinSync.dischargeOvercurrent);
  assign faultCond.dischargeShort = pinSync.dischargeShort;
  assign faultCond.dischargeOvercurrent = pinSync.dischargeOvercurrent;
  assign faultCond.chargeOvercurrent = pinSync.chargeOvercurrent;

  // Set wins over the read clear, so a live fault survives the read
  assign faultNext = faultCond | (faultReg & ~{6{readClr}});
  assign faultStatus = {2'b00, faultReg};

  // Unmapped pointer reads zero; reserved writes never land anywhere
  assign readData = (ptrReg == CFG_STATUS_ADDR) ? cfgStatus :
    (ptrReg == FAULT_STATUS_ADDR) ? faultStatus : UNMAPPED_READ;
  assign addrMatch = (shiftReg[7:1] == BUS_ADDR);
  assign loadTx = clkEn & sclFall &
    (((stateReg == BUS_RXACK) & (kindReg == BYTE_ADDR) & readModeReg) |
     (stateReg == BUS_TXACK));
  // Clear strobe at the moment the byte is captured for shifting out
  assign readClr = loadTx & (ptrReg == FAULT_STATUS_ADDR);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      faultReg <= FAULT_RESET;
    end else if (clkEn) begin
      faultReg <= faultNext;
    end
  end

  // Serial slave: sample on SCL rise, change SDA on SCL fall
  always_comb begin
    stateNext = stateReg;
    kindNext = kindReg;
    bitCntNext = bitCntReg;
    shiftNext = shiftReg;
    rxFullNext = rxFullReg;
    readModeNext = readModeReg;
    ptrNext = ptrReg;
    sdaOeNext = sdaOeReg;
    if (stopCond) begin
      stateNext = BUS_IDLE;
      sdaOeNext = 1'b0;
    end else if (startCond) begin
      stateNext = BUS_RX;
      kindNext = BYTE_ADDR;
      bitCntNext = BITCNT_RESET;
      rxFullNext = 1'b0;
      sdaOeNext = 1'b0;
    end else begin
      case (stateReg)
        BUS_RX: begin
          if (sclRise) begin
            shiftNext = {shiftReg[6:0], sdaSync};
            bitCntNext = bitCntReg + 3'h1;
            rxFullNext = (bitCntReg == 3'h7);
          end else if (sclFall && rxFullReg) begin
            rxFullNext = 1'b0;
            bitCntNext = BITCNT_RESET;
            if (kindReg != BYTE_ADDR || addrMatch) begin
              stateNext = BUS_RXACK;
              sdaOeNext = 1'b1;
            end else begin
              stateNext = BUS_IDLE;
            end
            if (kindReg == BYTE_ADDR) begin
              readModeNext = shiftReg[0];
            end
            if (kindReg == BYTE_PTR) begin
              ptrNext = shiftReg;
            end
            // Data bytes are acknowledged and dropped
          end
        end
        BUS_RXACK: begin
          if (sclFall) begin
            if (kindReg == BYTE_ADDR && readModeReg) begin
              stateNext = BUS_TX;
              shiftNext = readData;
              sdaOeNext = ~readData[7];
              ptrNext = ptrReg + 8'h01;
            end else begin
              stateNext = BUS_RX;
              sdaOeNext = 1'b0;
              kindNext = (kindReg == BYTE_ADDR) ? BYTE_PTR : BYTE_DATA;
            end
          end
        end
        BUS_TX: begin
          if (sclFall) begin
            bitCntNext = bitCntReg + 3'h1;
            if (bitCntReg == 3'h7) begin
              stateNext = BUS_TXACK;
              sdaOeNext = 1'b0;
            end else begin
              shiftNext = {shiftReg[6:0], 1'b0};
              sdaOeNext = ~shiftReg[6];
            end
          end
        end
        BUS_TXACK: begin
          if (sclRise && sdaSync) begin
            stateNext = BUS_IDLE;
          end else if (sclFall) begin
            stateNext = BUS_TX;
            shiftNext = readData;
            sdaOeNext = ~readData[7];
            ptrNext = ptrReg + 8'h01;
          end
        end
        default: begin
          stateNext = stateReg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= BUS_IDLE;
      kindReg <= BYTE_ADDR;
      bitCntReg <= BITCNT_RESET;
      shiftReg <= SHIFT_RESET;
      rxFullReg <= 1'b0;
      readModeReg <= 1'b0;
      ptrReg <= PTR_RESET;
      sdaOeReg <= 1'b0;
    end else if (clkEn) begin
      stateReg <= stateNext;
      kindReg <= kindNext;
      bitCntReg <= bitCntNext;
      shiftReg <= shiftNext;
      rxFullReg <= rxFullNext;
      readModeReg <= readModeNext;
      ptrReg <= ptrNext;
      sdaOeReg <= sdaOeNext;
    end
  end

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOeReg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_single_fe_set: assert property (
    cfgStatus[SINGLE_FE_BIT] == 1'b1 && readData[7:6] == 2'b00)
    else $error("single front end bit not set");

  chk_wake_pol_high: assert property (
    (wakePolarity && pinSync.wakeAbove) |-> cfgStatus[WAKE_BIT])
    else $error("wake bit wrong with high polarity");

  chk_wake_pol_low: assert property (
    (!wakePolarity && pinSync.wakeAbove) |-> !cfgStatus[WAKE_BIT])
    else $error("wake bit wrong with low polarity");

  chk_wake_live: assert property (
    ($stable(wakePolarity) && $changed(pinSync.wakeAbove))
    |-> $changed(cfgStatus[WAKE_BIT]))
    else $error("wake bit does not follow the pin");

  chk_ext_ot_set: assert property (
    (clkEn && pinSync.extOverTemp) |=> faultStatus[EXT_OT_BIT])
    else $error("external over-temperature flag not set");

  chk_int_ot_set: assert property (
    (clkEn && pinSync.intOverTemp) |=> faultReg.intOverTemp)
    else $error("internal over-temperature flag not set");

  chk_load_fail_set: assert property (
    (clkEn && loadMonitorEnable && pinSync.loadHeavy &&
     (pinSync.dischargeShort || pinSync.dischargeOvercurrent))
    |=> faultStatus[LOAD_FAIL_BIT])
    else $error("load fail flag not set");

  chk_short_held: assert property (
    (clkEn && pinSync.dischargeShort)[*2] |=> faultStatus[DIS_SHORT_BIT])
    else $error("discharge short flag not set");

  chk_dis_oc_rise: assert property (
    (clkEn && $rose(pinSync.dischargeOvercurrent))
    |=> faultStatus[DIS_OC_BIT])
    else $error("discharge overcurrent flag not set");

  chk_chg_oc_sticky: assert property (
    (clkEn && faultReg.chargeOvercurrent && !readClr) |=>
    faultStatus[CHG_OC_BIT])
    else $error("charge overcurrent flag lost without a read");

  chk_read_clear: assert property (
    readClr |=> faultReg == $past(faultCond))
    else $error("read clear left wrong fault flags");

  chk_write_ignored: assert property (
    (clkEn && stateReg == BUS_RX && kindReg == BYTE_DATA && !startCond)
    |=> $stable(ptrReg))
    else $error("data write disturbed the register pointer");

endmodule
`default_nettype wire

/* File: i2c_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
  parameter int H = 8
) (
  input wire logic clk,
  input wire logic sdaOe,
  output logic scl,
  output logic sdaIn,
  output logic rdDone,
  output logic [7:0] rdByte
);
  logic hostLow;
  // Pull-up: a released line reads high
  assign sdaIn = ~(hostLow | sdaOe);
  initial begin
    scl = 1'b1;
    hostLow = 1'b0;
    rdDone = 1'b0;
    rdByte = 8'h00;
  end
  task automatic waitH(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves a few cycles after SCL falls, never with it
  task automatic bitX(input logic b, output logic r);
    waitH(4);
    hostLow = ~b;
    waitH(H);
    scl = 1'b1;
    waitH(H);
    r = sdaIn;
    scl = 1'b0;
  endtask
  task automatic start();
    waitH(4);
    hostLow = 1'b0;
    waitH(H);
    scl = 1'b1;
    waitH(H);
    hostLow = 1'b1;
    waitH(H);
    scl = 1'b0;
  endtask
  task automatic stop();
    waitH(4);
    hostLow = 1'b1;
    waitH(H);
    scl = 1'b1;
    waitH(H);
    hostLow = 1'b0;
    waitH(H);
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitX(b[i], r);
    bitX(1'b1, r);
    ack = ~r;
  endtask
  task automatic readByte(input logic last);
    logic r;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      bitX(1'b1, r);
      d = {d[6:0], r};
    end
    rdByte = d;
    rdDone = 1'b1;
    waitH(1);
    rdDone = 1'b0;
    bitX(last, r);
  endtask
endmodule
`default_nettype wire

/* File: pack_protection_status_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
module pack_protection_status_regs_test
  import pack_status_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic wakePolarity = 1'b0;
  logic loadMonitorEnable = 1'b0;
  logic scl, sdaIn, sdaOut, sdaOe, rdDone;
  logic [7:0] rdByte;
  pin_in_s pins = PIN_RESET;
  logic [7:0] expQ[$];
  int nMismatch = 0;
  int nChecks = 0;
  integer seed = 32'h632D;
  always #2 clk = ~clk;
  pack_protection_status_regs dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .pins(pins),
    .wakePolarity(wakePolarity), .loadMonitorEnable(loadMonitorEnable));
  i2c_host_model host (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn),
    .rdDone(rdDone), .rdByte(rdByte));
  task automatic check(input string w, input logic [7:0] e, g);
    nChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [7:0] cfgExp(input logic pol, above);
    cfgExp = 8'h00;
    cfgExp[SINGLE_FE_BIT] = SINGLE_FE_VALUE;
    cfgExp[WAKE_BIT] = pol ~^ above;
  endfunction
  function automatic logic [7:0] faultExp(input pin_in_s p, input logic m);
    faultExp = {2'b00, p.extOverTemp, p.intOverTemp,
      m & p.loadHeavy & (p.dischargeShort | p.dischargeOvercurrent),
      p.dischargeShort, p.dischargeOvercurrent, p.chargeOvercurrent};
  endfunction
  task automatic addr(input logic rd);
    logic a;
    host.sendByte({DEF_BUS_ADDR, rd}, a);
    check("addressAck", 8'h01, {7'h00, a});
  endtask
  task automatic readAt(input logic [7:0] ptr, input int n);
    logic a;
    host.start();
    addr(1'b0);
    host.sendByte(ptr, a);
    host.start();
    addr(1'b1);
    for (int i = 1; i <= n; i++) host.readByte(i == n);
    host.stop();
  endtask
  // Data bytes are acknowledged even though nothing is stored
  task automatic writeAt(input logic [7:0] ptr);
    logic a;
    host.start();
    addr(1'b0);
    host.sendByte(ptr, a);
    host.sendByte(8'hFF, a);
    check("dataAck", 8'h01, {7'h00, a});
    host.stop();
  endtask
  always @(posedge clk) begin
    if (rdDone === 1'b1) begin
      if (expQ.size() == 0) check("extraByte", 8'h00, 8'hXX);
      else check("readByte", expQ.pop_front(), rdByte);
    end
  end
  initial begin
    logic [6:0] pv;
    logic lme;
    logic a;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      wakePolarity = k[1];
      pins.wakeAbove = k[0];
      expQ.push_back(cfgExp(k[1], k[0]));
      readAt(CFG_STATUS_ADDR, 1);
    end
    writeAt(CFG_STATUS_ADDR);
    writeAt(FAULT_STATUS_ADDR);
    expQ.push_back(UNMAPPED_READ);
    expQ.push_back(cfgExp(1'b1, 1'b1));
    expQ.push_back(8'h00);
    readAt(8'hFF, 3);
    // Singles first, then mixes; a read under a live fault must not clear
    for (int i = 0; i < 10; i++) begin
      pv = (i < 5) ? 7'h04 << i : (i == 5) ? 7'h12 : 7'($random(seed));
      lme = (i == 5) ? 1'b1 : 1'($random(seed));
      pins = pin_in_s'(pv);
      loadMonitorEnable = lme;
      expQ.push_back(faultExp(pin_in_s'(pv), lme));
      readAt(FAULT_STATUS_ADDR, 1);
      pins = PIN_RESET;
      expQ.push_back(faultExp(pin_in_s'(pv), lme));
      readAt(FAULT_STATUS_ADDR, 1);
      expQ.push_back(8'h00);
      readAt(FAULT_STATUS_ADDR, 1);
    end
    // Frozen enable must hide a fault pulse, synchronisers included
    clkEn = 1'b0;
    pins = pin_in_s'(7'h7C);
    repeat (8) @(negedge clk);
    pins = PIN_RESET;
    repeat (8) @(negedge clk);
    clkEn = 1'b1;
    expQ.push_back(8'h00);
    readAt(FAULT_STATUS_ADDR, 1);
    host.start();
    host.sendByte({DEF_BUS_ADDR ^ 7'h01, 1'b0}, a);
    check("foreignAck", 8'h00, {7'h00, a});
    host.stop();
    check("sdaOut", 8'h00, {7'h00, sdaOut});
    repeat (10) @(negedge clk);
    check("pending", 8'h00, 8'(expQ.size()));
    giveVerdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    nMismatch++;
    giveVerdict();
  end
endmodule
`default_nettype wire
